// ---- common/scss_cfg.svh ----
// constants of the system clock select switch: offsets, fields, resets, counts
`ifndef SCSS_CFG_SVH
`define SCSS_CFG_SVH

// ********************************************************************
// register offsets
// ********************************************************************
`define SCSS_ADDR_W 2
`define SCSS_OFF_OSC_CTRL 2'h0
`define SCSS_OFF_TIMER_CTRL 2'h1
`define SCSS_OFF_OSC_STATUS 2'h2

// ********************************************************************
// field positions
// ********************************************************************
`define SCSS_CTRL_SCS_LO 0
`define SCSS_CTRL_SCS_HI 1
`define SCSS_CTRL_IFS_LO 4
`define SCSS_CTRL_IFS_HI 6
`define SCSS_TMR_SEC_EN_BIT 3
`define SCSS_STAT_HF_BIT 0
`define SCSS_STAT_STARTUP_TIMEOUT_STATUS_BIT 1
`define SCSS_STAT_SRC_LO 2
`define SCSS_STAT_SRC_HI 3
`define SCSS_STAT_SWITCH_BIT 4
`define SCSS_STAT_CFG_BIT 5
`define SCSS_STAT_IGN_BIT 6

// ********************************************************************
// reset values and encodings
// ********************************************************************
`define SCSS_SCS_RESET 2'h0
`define SCSS_IFS_RESET 3'h6
`define SCSS_SCS_PRIMARY 2'h0
`define SCSS_SCS_SECONDARY 2'h1
`define SCSS_CFG_INT_A 4'h8
`define SCSS_CFG_INT_B 4'h9

// ********************************************************************
// pause lengths in source edges
// ********************************************************************
`define SCSS_OLD_EDGES 3'h2
`define SCSS_NEW_EDGES 3'h3

`endif

// ---- common/scss_pkg.sv ----
// types of the system clock select switch
package scss_pkg;
    // clock sources, also the index into the synchronised source vector
    typedef enum logic [1:0] {
        SRC_LF,
        SRC_HF,
        SRC_PRI,
        SRC_SEC
    } scss_src_type;

    // switch sequencer states
    typedef enum logic [2:0] {
        ST_PWRUP,
        ST_RUN,
        ST_WAIT_RDY,
        ST_OLD_PAUSE,
        ST_NEW_PAUSE
    } scss_state_type;
endpackage

// ---- verification/scss_osc_model.sv ----
// behavioural oscillators and primary ready for the switch
`timescale 1ns/10ps
module scss_osc_model #(
    parameter int PRI_START_NS = 2000
) (
    // enables from the switch
    input wire logic lf_enable_in,
    input wire logic hf_enable_in,
    input wire logic pri_enable_in,
    input wire logic sec_enable_in,
    // oscillator levels, low while stopped
    output logic osc_lf_out,
    output logic osc_hf_out,
    output logic osc_pri_out,
    output logic osc_sec_out,
    output logic pri_ready_out
);
    // ****
    // sources, all slow enough to be sampled
    // ****
    initial begin
        {osc_lf_out, osc_hf_out, osc_pri_out, osc_sec_out} = 4'h0;
        pri_ready_out = 1'b0;
    end
    // a stopped source sits low, never frozen high
    always #80 osc_lf_out = lf_enable_in & ~osc_lf_out;
    always #40 osc_hf_out = hf_enable_in & ~osc_hf_out;
    always #60 osc_pri_out = pri_enable_in & ~osc_pri_out;
    // secondary is stable from its first cycle once enabled
    always #100 osc_sec_out = sec_enable_in & ~osc_sec_out;
    // primary reports ready only after its start-up span
    always @(pri_enable_in) begin
        pri_ready_out = 1'b0;
        if (pri_enable_in) begin
            #(PRI_START_NS) pri_ready_out = pri_enable_in;
        end
    end
endmodule

// ---- verification/scss_top_sva.sv ----
// port checker of the clock select switch
`timescale 1ns/10ps
`include "scss_cfg.svh"
module scss_top_sva (
    // clock and reset
    input logic clk_sys_in,
    input logic rst_in,
    // register port
    input logic [`SCSS_ADDR_W-1:0] reg_addr_in,
    input logic [7:0] reg_wdata_in,
    input logic reg_wr_in,
    // primary ready
    input logic pri_ready_in,
    // switch outputs
    input logic lf_enable_out,
    input logic hf_enable_out,
    input logic pri_enable_out,
    input logic sec_enable_out,
    input logic [2:0] internal_freq_select_out,
    input logic clk_dev_out,
    input scss_pkg::scss_src_type clk_src_out
);
    import scss_pkg::*;
    logic [7:0] low_cnt_r;
    logic [7:0] wdata_r;
    // run of low device clock cycles, saturating
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || clk_dev_out) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != 8'hFF) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    // last write data, so the write effect is seen one cycle on
    always_ff @(posedge clk_sys_in) begin
        wdata_r <= reg_wdata_in;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // ****
    // properties
    // ****
    a_reset_defaults: assert property (
        $fell(rst_in) |-> clk_src_out == SRC_LF && !clk_dev_out
            && internal_freq_select_out == 3'h6)
        else $error("wrong source or divider after reset");
    a_lf_always_on: assert property (lf_enable_out)
        else $error("low-frequency source switched off");
    a_pause_length: assert property (
        $changed(clk_src_out) && !$past(rst_in) |-> low_cnt_r >= 8'h14)
        else $error("clock pause too short");
    a_clean_release: assert property (
        $changed(clk_src_out) && !$past(rst_in)
        |-> !clk_dev_out ##1 clk_dev_out)
        else $error("device clock not released cleanly");
    a_pri_after_ready: assert property (
        $changed(clk_src_out) && clk_src_out == SRC_PRI
        |-> $past(pri_ready_in, 3))
        else $error("primary taken before ready");
    a_sec_needs_enable: assert property (
        clk_src_out != SRC_SEC && !sec_enable_out |=> clk_src_out != SRC_SEC)
        else $error("secondary taken while disabled");
    a_running_powered: assert property (
        (clk_src_out == SRC_HF |-> hf_enable_out)
        and (clk_src_out == SRC_PRI |-> pri_enable_out))
        else $error("current source not enabled");
    a_divider_write: assert property (
        reg_wr_in && reg_addr_in == `SCSS_OFF_OSC_CTRL
        |=> internal_freq_select_out == wdata_r[6:4])
        else $error("divider field not taken from write");
    a_sec_enable_write: assert property (
        reg_wr_in && reg_addr_in == `SCSS_OFF_TIMER_CTRL
        |=> sec_enable_out == wdata_r[3])
        else $error("secondary enable not taken from write");
    c_to_hf: cover property ($changed(clk_src_out) && clk_src_out == SRC_HF);
    c_to_sec: cover property ($changed(clk_src_out) && clk_src_out == SRC_SEC);
    c_to_pri: cover property ($changed(clk_src_out) && clk_src_out == SRC_PRI);
endmodule

bind scss_top scss_top_sva u_sva (
    .clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .pri_ready_in, .lf_enable_out, .hf_enable_out, .pri_enable_out,
    .sec_enable_out, .internal_freq_select_out, .clk_dev_out,
    .clk_src_out
);

// ---- verification/tb.sv ----
// self-checking bench of the clock select switch
`timescale 1ns/10ps
module tb;
    import scss_pkg::*;
    typedef struct packed {
        logic [1:0] a;
        logic [7:0] d;
        logic [7:0] r;
    } scss_row_type;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] reg_addr_in = 2'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [3:0] primary_osc_config_in = 4'h8;
    logic config_loaded_in = 1'b0;
    logic sleep_req_in = 1'b0;
    logic wake_req_in = 1'b0;
    logic [7:0] reg_rdata_out, rv, ex;
    logic osc_lf_in, osc_hf_in, osc_pri_in, osc_sec_in, pri_ready_in;
    logic lf_enable_out, hf_enable_out, pri_enable_out, sec_enable_out;
    logic [2:0] internal_freq_select_out;
    logic clk_dev_out, sleep_out;
    scss_src_type clk_src_out;
    int n_fail = 0;
    int cmp_count = 0;
    wire [7:0] ens = {4'h0, lf_enable_out, hf_enable_out, pri_enable_out,
        sec_enable_out};
    // ordinary cases: index, write data, read back
    scss_row_type rows [8] = '{
        '{2'h0, 8'h50, 8'h50}, '{2'h0, 8'h72, 8'h72},
        '{2'h0, 8'h13, 8'h13}, '{2'h0, 8'h60, 8'h60},
        '{2'h1, 8'h08, 8'h08}, '{2'h1, 8'h00, 8'h00},
        '{2'h3, 8'hFF, 8'h00}, '{2'h2, 8'hFF, 8'h25}};
    // 100 MHz system clock
    always #5 clk_sys_in = ~clk_sys_in;
    scss_top DUT (
        .clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .primary_osc_config_in,
        .config_loaded_in, .sleep_req_in, .wake_req_in, .osc_lf_in,
        .osc_hf_in, .osc_pri_in, .osc_sec_in, .pri_ready_in,
        .lf_enable_out, .hf_enable_out, .pri_enable_out, .sec_enable_out,
        .internal_freq_select_out, .clk_dev_out, .clk_src_out, .sleep_out);
    scss_osc_model u_osc (
        .lf_enable_in(lf_enable_out), .hf_enable_in(hf_enable_out),
        .pri_enable_in(pri_enable_out), .sec_enable_in(sec_enable_out),
        .osc_lf_out(osc_lf_in), .osc_hf_out(osc_hf_in),
        .osc_pri_out(osc_pri_in), .osc_sec_out(osc_sec_in),
        .pri_ready_out(pri_ready_in));
    // ****
    // tasks
    // ****
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task automatic pwr(input logic s, input logic w);
        @(posedge clk_sys_in);
        sleep_req_in <= s;
        wake_req_in <= w;
        @(posedge clk_sys_in);
        sleep_req_in <= 1'b0;
        wake_req_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // bounded wait, switches take up to a few hundred cycles
    task automatic wait_src(input scss_src_type s);
        for (int k = 0; k < 600 && clk_src_out !== s; k++) begin
            @(posedge clk_sys_in);
        end
        #1 chk("clk_src", 8'(s), 8'(clk_src_out));
    endtask
    task automatic saw_clk(output logic [7:0] v);
        v = 8'h00;
        repeat (40) @(negedge clk_sys_in) v = v | 8'(clk_dev_out);
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****
    // sequence
    // ****
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        #1 chk("clk_src", 8'(SRC_LF), 8'(clk_src_out));
        chk("ifs", 8'h06, 8'(internal_freq_select_out));
        chk("enables", 8'h08, ens);
        saw_clk(rv);
        chk("clk_dev", 8'h01, rv);
        rd(2'h2, rv);
        chk("status", 8'h10, rv & 8'h30);
        @(posedge clk_sys_in);
        config_loaded_in <= 1'b1;
        wait_src(SRC_HF);
        rd(2'h2, rv);
        chk("status", 8'h25, rv & 8'h7F);
        foreach (rows[j]) begin
            wr(rows[j].a, rows[j].d);
            rd(rows[j].a, rv);
            chk("readback", rows[j].r, rv);
            ex = 8'(rows[j].d[6:4]);
            if (rows[j].a == 2'h0) begin
                chk("ifs", ex, 8'(internal_freq_select_out));
                chk("clk_src", 8'(SRC_HF), 8'(clk_src_out));
            end
            if (rows[j].a == 2'h1) begin
                chk("sec", 8'(rows[j].d[3]), 8'(sec_enable_out));
            end
        end
        // secondary chosen while its oscillator is off, then sleep
        wr(2'h0, 8'h61);
        pwr(1'b1, 1'b0);
        repeat (100) @(posedge clk_sys_in);
        #1 chk("clk_src", 8'(SRC_HF), 8'(clk_src_out));
        rd(2'h2, rv);
        chk("ignored", 8'h40, rv & 8'h40);
        chk("sleep", 8'h01, 8'(sleep_out));
        pwr(1'b0, 1'b1);
        #1 chk("sleep", 8'h00, 8'(sleep_out));
        // enable first and let it settle before selecting it
        wr(2'h1, 8'h08);
        repeat (100) @(posedge clk_sys_in);
        wr(2'h0, 8'h61);
        wait_src(SRC_SEC);
        pwr(1'b1, 1'b0);
        rd(2'h2, rv);
        chk("ignored", 8'h00, rv & 8'h40);
        pwr(1'b0, 1'b1);
        wr(2'h0, 8'h62);
        wait_src(SRC_HF);
        // external primary: reset clears select, wait for ready
        @(posedge clk_sys_in);
        primary_osc_config_in <= 4'h2;
        config_loaded_in <= 1'b0;
        rst_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(2'h0, rv);
        chk("select", 8'h60, rv);
        chk("clk_src", 8'(SRC_LF), 8'(clk_src_out));
        @(posedge clk_sys_in);
        config_loaded_in <= 1'b1;
        saw_clk(rv);
        chk("clk_dev", 8'h01, rv);
        chk("clk_src", 8'(SRC_LF), 8'(clk_src_out));
        chk("pri_en", 8'h01, 8'(pri_enable_out));
        wait_src(SRC_PRI);
        rd(2'h2, rv);
        chk("status", 8'h2A, rv & 8'h3F);
        // second internal configuration also lands on the fast source
        @(posedge clk_sys_in);
        primary_osc_config_in <= 4'h9;
        config_loaded_in <= 1'b0;
        rst_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        config_loaded_in <= 1'b1;
        wait_src(SRC_HF);
        rd(2'h2, rv);
        chk("status", 8'h25, rv & 8'h7F);
        give_verdict();
    end
    // watchdog, far beyond the thousand or so cycles needed
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
endmodule

// ---- verilog/scss_osc_sync.sv ----
// two-flop synchronisers with edge detection for the oscillator inputs
`timescale 1ns/10ps
module scss_osc_sync #(
    parameter int N = 5
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // raw levels from outside the clock domain
    input wire logic [N-1:0] async_in,
    // synchronised level and one-cycle edge pulses
    output logic [N-1:0] lvl_out,
    output logic [N-1:0] rise_out,
    output logic [N-1:0] fall_out
);
    logic [N-1:0] meta_r;
    logic [N-1:0] prev_r;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            // first flop only feeds the second; edges use the second onward
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    meta_r[i] <= 1'b0;
                    lvl_out[i] <= 1'b0;
                    prev_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= async_in[i];
                    lvl_out[i] <= meta_r[i];
                    prev_r[i] <= lvl_out[i];
                end
            end
            assign rise_out[i] = lvl_out[i] & ~prev_r[i];
            assign fall_out[i] = ~lvl_out[i] & prev_r[i];
        end
    endgenerate
endmodule

// ---- verilog/scss_top.sv ----
// system clock source selection and glitch-free switch
`timescale 1ns/10ps
`include "scss_cfg.svh"
module scss_top (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register port
    input wire logic [`SCSS_ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // configuration loader, same clock
    input wire logic [3:0] primary_osc_config_in,
    input wire logic config_loaded_in,
    // core power requests, same clock
    input wire logic sleep_req_in,
    input wire logic wake_req_in,
    // oscillator levels and primary ready, asynchronous
    input wire logic osc_lf_in,
    input wire logic osc_hf_in,
    input wire logic osc_pri_in,
    input wire logic osc_sec_in,
    input wire logic pri_ready_in,
    // oscillator controls
    output logic lf_enable_out,
    output logic hf_enable_out,
    output logic pri_enable_out,
    output logic sec_enable_out,
    output logic [2:0] internal_freq_select_out,
    // device clock and state
    output logic clk_dev_out,
    output scss_pkg::scss_src_type clk_src_out,
    output logic sleep_out
);
    import scss_pkg::*;

    // ****************************************************************
    // synchronised oscillator inputs
    // ****************************************************************
    logic [4:0] lvl;
    logic [4:0] rise;
    logic [4:0] fall;

    scss_osc_sync #(.N(5)) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .async_in({pri_ready_in, osc_sec_in, osc_pri_in, osc_hf_in,
                   osc_lf_in}),
        .lvl_out(lvl),
        .rise_out(rise),
        .fall_out(fall)
    );

    wire logic pri_ready = lvl[4];

    // ****************************************************************
    // state
    // ****************************************************************
    scss_state_type state_r;
    scss_src_type cur_r;
    scss_src_type tgt_r;
    scss_src_type tgt_nxt;
    scss_src_type prim_src;
    logic [1:0] clock_source_select_r;
    logic [2:0] internal_freq_select_r;
    logic secondary_osc_enable_r;
    logic [3:0] cfg_r;
    logic cfg_valid_r;
    logic hf_internal_stable_flag_r;
    logic startup_timeout_status_r;
    logic sec_ignored_r;
    logic gate_r;
    logic [2:0] cnt_r;
    logic clk_dev_r;
    logic sleep_r;
    logic [7:0] rdata_r;

    wire logic ctrl_wr = reg_wr_in && (reg_addr_in == `SCSS_OFF_OSC_CTRL);
    wire logic tmr_wr = reg_wr_in && (reg_addr_in == `SCSS_OFF_TIMER_CTRL);
    wire logic sec_sleep_bad = sleep_req_in && !secondary_osc_enable_r &&
        (clock_source_select_r == `SCSS_SCS_SECONDARY);

    // ****************************************************************
    // target decode
    // ****************************************************************
    // internal-oscillator configurations land on the fast oscillator
    always_comb begin
        if (cfg_r == `SCSS_CFG_INT_A || cfg_r == `SCSS_CFG_INT_B) begin
            prim_src = SRC_HF;
        end else begin
            prim_src = SRC_PRI;
        end
    end

    // 00 primary, 01 secondary, both 1x encodings the internal block
    always_comb begin
        unique case (clock_source_select_r)
            2'h0: tgt_nxt = prim_src;
            2'h1: begin
                // a disabled secondary is never chosen: stay put
                if (secondary_osc_enable_r) begin
                    tgt_nxt = SRC_SEC;
                end else begin
                    tgt_nxt = cur_r;
                end
            end
            2'h2: tgt_nxt = SRC_HF;
            2'h3: tgt_nxt = SRC_HF;
        endcase
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    // source and frequency select; reset clears the source select
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            clock_source_select_r <= `SCSS_SCS_RESET;
            internal_freq_select_r <= `SCSS_IFS_RESET;
        end else if (ctrl_wr) begin
            clock_source_select_r <=
                reg_wdata_in[`SCSS_CTRL_SCS_HI:`SCSS_CTRL_SCS_LO];
            internal_freq_select_r <=
                reg_wdata_in[`SCSS_CTRL_IFS_HI:`SCSS_CTRL_IFS_LO];
        end
    end

    // secondary oscillator enable in the timer control byte
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            secondary_osc_enable_r <= 1'b0;
        end else if (tmr_wr) begin
            secondary_osc_enable_r <= reg_wdata_in[`SCSS_TMR_SEC_EN_BIT];
        end
    end

    // sticky note of an ignored secondary request; set beats the clear
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sec_ignored_r <= 1'b0;
        end else if (sec_sleep_bad) begin
            sec_ignored_r <= 1'b1;
        end else if (ctrl_wr) begin
            sec_ignored_r <= 1'b0;
        end
    end

    // sleep level; the source is left alone on entry
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sleep_r <= 1'b0;
        end else if (sleep_req_in) begin
            sleep_r <= 1'b1;
        end else if (wake_req_in) begin
            sleep_r <= 1'b0;
        end
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_r <= 8'h00;
        end else if (reg_rd_in) begin
            rdata_r <= 8'h00;
            unique case (reg_addr_in)
                `SCSS_OFF_OSC_CTRL: begin
                    rdata_r[`SCSS_CTRL_SCS_HI:`SCSS_CTRL_SCS_LO] <=
                        clock_source_select_r;
                    rdata_r[`SCSS_CTRL_IFS_HI:`SCSS_CTRL_IFS_LO] <=
                        internal_freq_select_r;
                end
                `SCSS_OFF_TIMER_CTRL: begin
                    rdata_r[`SCSS_TMR_SEC_EN_BIT] <= secondary_osc_enable_r;
                end
                `SCSS_OFF_OSC_STATUS: begin
                    rdata_r[`SCSS_STAT_HF_BIT] <= hf_internal_stable_flag_r;
                    rdata_r[`SCSS_STAT_STARTUP_TIMEOUT_STATUS_BIT] <= startup_timeout_status_r;
                    rdata_r[`SCSS_STAT_SRC_HI:`SCSS_STAT_SRC_LO] <= cur_r;
                    rdata_r[`SCSS_STAT_SWITCH_BIT] <= (state_r != ST_RUN);
                    rdata_r[`SCSS_STAT_CFG_BIT] <= cfg_valid_r;
                    rdata_r[`SCSS_STAT_IGN_BIT] <= sec_ignored_r;
                end
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ****************************************************************
    // switch sequencer
    // ****************************************************************
    // the old source is stopped on a falling edge so the last high
    // phase is whole; the new one is opened on a rising edge
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_r <= ST_PWRUP;
            cur_r <= SRC_LF;
            tgt_r <= SRC_LF;
            cfg_r <= 4'h0;
            cfg_valid_r <= 1'b0;
            gate_r <= 1'b1;
            cnt_r <= 3'h0;
            hf_internal_stable_flag_r <= 1'b0;
            startup_timeout_status_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_PWRUP: begin
                    // config captured only once the loader says so
                    if (config_loaded_in) begin
                        cfg_r <= primary_osc_config_in;
                        cfg_valid_r <= 1'b1;
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (tgt_nxt != cur_r) begin
                        tgt_r <= tgt_nxt;
                        cnt_r <= 3'h0;
                        if (tgt_nxt == SRC_PRI && !pri_ready) begin
                            state_r <= ST_WAIT_RDY;
                        end else begin
                            state_r <= ST_OLD_PAUSE;
                        end
                    end
                end
                ST_WAIT_RDY: begin
                    // old source keeps clocking the core meanwhile
                    if (tgt_nxt != tgt_r) begin
                        state_r <= ST_RUN;
                    end else if (pri_ready) begin
                        state_r <= ST_OLD_PAUSE;
                    end
                end
                ST_OLD_PAUSE: begin
                    // first fall closes the gate, two whole old periods
                    // then pass low before the new source is counted
                    if (fall[cur_r]) begin
                        gate_r <= 1'b0;
                        if (cnt_r == `SCSS_OLD_EDGES) begin
                            cnt_r <= 3'h0;
                            state_r <= ST_NEW_PAUSE;
                        end else begin
                            cnt_r <= cnt_r + 3'h1;
                        end
                    end
                end
                ST_NEW_PAUSE: begin
                    // three counted rises, released on the next: 3 to 4
                    if (rise[tgt_r]) begin
                        if (cnt_r == `SCSS_NEW_EDGES) begin
                            cur_r <= tgt_r;
                            gate_r <= 1'b1;
                            state_r <= ST_RUN;
                            hf_internal_stable_flag_r <= (tgt_r == SRC_HF);
                            startup_timeout_status_r <=
                                (tgt_r == SRC_PRI);
                        end else begin
                            cnt_r <= cnt_r + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // gated device clock, low through the whole pause
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            clk_dev_r <= 1'b0;
        end else begin
            clk_dev_r <= gate_r & lvl[cur_r];
        end
    end

    // ****************************************************************
    // oscillator enables
    // ****************************************************************
    // low-frequency oscillator runs from power-up regardless of config
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            lf_enable_out <= 1'b1;
            hf_enable_out <= 1'b0;
            pri_enable_out <= 1'b0;
        end else begin
            lf_enable_out <= 1'b1;
            hf_enable_out <= (cur_r == SRC_HF) || (tgt_r == SRC_HF);
            pri_enable_out <= (cur_r == SRC_PRI) || (tgt_r == SRC_PRI);
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata_out = rdata_r;
    assign sec_enable_out = secondary_osc_enable_r;
    assign internal_freq_select_out = internal_freq_select_r;
    assign clk_dev_out = clk_dev_r;
    assign clk_src_out = cur_r;
    assign sleep_out = sleep_r;
endmodule
